// ===== eca_pkg.sv
// Shared constants and carrier types for the EEPROM command access block
package eca_pkg;
	localparam logic [7:0]  CMD_RESTORE_DEFAULT = 8'h12;
	localparam logic [7:0]  CMD_STORE_USER      = 8'h15;
	localparam logic [7:0]  CMD_RESTORE_USER    = 8'h16;
	localparam logic [3:0]  CMD_DATA_NIBBLE     = 4'hb;
	localparam logic [7:0]  CMD_CHECKSUM        = 8'hd1;
	localparam logic [7:0]  CMD_RD_LEN          = 8'hd2;
	localparam logic [7:0]  CMD_OFFSET          = 8'hd3;
	localparam logic [7:0]  CMD_ERASE           = 8'hd4;
	localparam logic [7:0]  CMD_NVM_KEY         = 8'hd5;
	localparam logic [7:0]  CMD_TRIM_KEY        = 8'hd6;
	localparam logic [7:0]  CMD_FLAG_INFO       = 8'hf1;
	localparam logic [3:0]  PAGE_DEFAULT        = 4'h0;
	localparam logic [3:0]  PAGE_USER           = 4'h1;
	localparam logic [7:0]  PAGE_FIRST_WR       = 8'h04;
	localparam logic [7:0]  PAGE_LAST           = 8'h0f;
	localparam logic [7:0]  KEY_RST             = 8'hff;
	localparam logic [7:0]  LEN_RST             = 8'h00;
	localparam logic [15:0] OFFSET_RST          = 16'h0000;
	localparam logic [7:0]  CRC_RST             = 8'h00;
	localparam int          ERASE_WAIT_MS       = 35;

	typedef enum logic [2:0] {
		OP_NONE    = 3'b000,
		OP_READ    = 3'b001,
		OP_WRITE   = 3'b010,
		OP_ERASE   = 3'b011,
		OP_STORE   = 3'b100,
		OP_RESTORE = 3'b101
	} eca_op_t;

	typedef struct packed {
		logic        valid;
		logic        write;
		logic [7:0]  code;
		logic [15:0] data;
	} eca_cmd_t;

	typedef struct packed {
		eca_op_t     op;
		logic [3:0]  page;
		logic [15:0] offset;
		logic [7:0]  count;
		logic [7:0]  data;
	} eca_nvm_t;
endpackage : eca_pkg

// ===== eca_core.sv
// EEPROM command access: lock keys, erase gating, page ops and readback
module eca_core (
	input  wire logic              clk,
	input  wire logic              nrst,
	input  wire eca_pkg::eca_cmd_t cmd,
	input  wire logic              crc_valid,
	input  wire logic [7:0]        crc_value,
	input  wire logic [7:0]        flag_info,
	output logic                   rsp_valid,
	output logic [15:0]            rsp_data,
	output eca_pkg::eca_nvm_t      nvm_req,
	output logic                   nvm_unlocked,
	output logic                   trim_unlocked,
	output logic                   cmd_refused
);
	logic        wr;
	logic        rd;
	logic        is_data;
	logic        erase_ok;
	logic [7:0]  crc_q;
	logic [7:0]  len_q;
	logic [15:0] offset_q;
	logic [7:0]  key_q;
	logic        key_pend_q;
	logic [7:0]  key_first_q;
	logic        trim_pend_q;

	assign wr       = cmd.valid && cmd.write;
	assign rd       = cmd.valid && !cmd.write;
	assign is_data  = cmd.code[7:4] == eca_pkg::CMD_DATA_NIBBLE;
	// Range check on the whole byte so values above 15 cannot alias a page
	assign erase_ok = nvm_unlocked && cmd.data[7:0] >= eca_pkg::PAGE_FIRST_WR &&
		cmd.data[7:0] <= eca_pkg::PAGE_LAST;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			crc_q <= eca_pkg::CRC_RST;
		end else if (crc_valid) begin
			crc_q <= crc_value;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			len_q    <= eca_pkg::LEN_RST;
			offset_q <= eca_pkg::OFFSET_RST;
		end else if (wr && cmd.code == eca_pkg::CMD_RD_LEN) begin
			len_q <= cmd.data[7:0];
		end else if (wr && cmd.code == eca_pkg::CMD_OFFSET) begin
			offset_q <= cmd.data;
		end
	end

	// EEPROM key sequence; once open the lock stays open until reset
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			key_q        <= eca_pkg::KEY_RST;
			key_pend_q   <= 1'b0;
			key_first_q  <= 8'h00;
			nvm_unlocked <= 1'b0;
		end else if (wr && cmd.code == eca_pkg::CMD_NVM_KEY) begin
			if (key_pend_q && cmd.data[7:0] == key_first_q) begin
				key_pend_q <= 1'b0;
				if (cmd.data[7:0] == key_q) begin
					nvm_unlocked <= 1'b1;
				end else if (nvm_unlocked) begin
					key_q <= cmd.data[7:0];
				end
			end else begin
				key_pend_q  <= 1'b1;
				key_first_q <= cmd.data[7:0];
			end
		end else if (cmd.valid) begin
			key_pend_q <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			trim_pend_q   <= 1'b0;
			trim_unlocked <= 1'b0;
		end else if (wr && cmd.code == eca_pkg::CMD_TRIM_KEY) begin
			if (cmd.data[7:0] != key_q) begin
				trim_pend_q   <= 1'b0;
				trim_unlocked <= 1'b0;
			end else if (trim_pend_q) begin
				trim_pend_q   <= 1'b0;
				trim_unlocked <= 1'b1;
			end else begin
				trim_pend_q <= 1'b1;
			end
		end else if (cmd.valid) begin
			trim_pend_q <= 1'b0;
		end
	end

	// Register readback; write-only codes answer zero and flag a refusal
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rsp_valid <= 1'b0;
			rsp_data  <= 16'h0000;
		end else begin
			rsp_valid <= 1'b0;
			rsp_data  <= 16'h0000;
			if (rd) begin
				unique case (cmd.code)
					eca_pkg::CMD_CHECKSUM: begin
						rsp_valid <= 1'b1;
						rsp_data  <= {8'h00, crc_q};
					end
					eca_pkg::CMD_RD_LEN: begin
						rsp_valid <= 1'b1;
						rsp_data  <= {8'h00, len_q};
					end
					eca_pkg::CMD_OFFSET: begin
						rsp_valid <= 1'b1;
						rsp_data  <= offset_q;
					end
					eca_pkg::CMD_FLAG_INFO: begin
						rsp_valid <= 1'b1;
						rsp_data  <= {8'h00, flag_info};
					end
					eca_pkg::CMD_ERASE, eca_pkg::CMD_NVM_KEY, eca_pkg::CMD_TRIM_KEY: begin
						rsp_valid <= 1'b1;
					end
					default: begin
						rsp_valid <= 1'b0;
					end
				endcase
			end
		end
	end

	// Array requests; one-cycle op, fields hold until the next op
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			nvm_req <= '{op: eca_pkg::OP_NONE, page: 4'h0, offset: 16'h0000,
				count: 8'h00, data: 8'h00};
			cmd_refused <= 1'b0;
		end else begin
			nvm_req.op  <= eca_pkg::OP_NONE;
			cmd_refused <= 1'b0;
			if (cmd.valid && is_data) begin
				// Refused writes keep the fields of the last op standing
				if (!cmd.write || {4'h0, cmd.code[3:0]} >= eca_pkg::PAGE_FIRST_WR) begin
					nvm_req.op     <= cmd.write ? eca_pkg::OP_WRITE : eca_pkg::OP_READ;
					nvm_req.page   <= cmd.code[3:0];
					nvm_req.offset <= offset_q;
					nvm_req.count  <= len_q;
					nvm_req.data   <= cmd.data[7:0];
				end else begin
					cmd_refused <= 1'b1;
				end
			end else if (wr && cmd.code == eca_pkg::CMD_ERASE) begin
				// Pages 0 to 3 are refused; only pages 4 to 15 are erased, and only while unlocked
				if (erase_ok) begin
					nvm_req.op   <= eca_pkg::OP_ERASE;
					nvm_req.page <= cmd.data[3:0];
				end else begin
					cmd_refused <= 1'b1;
				end
			end else if (cmd.valid && cmd.code == eca_pkg::CMD_STORE_USER) begin
				if (nvm_unlocked) begin
					nvm_req.op   <= eca_pkg::OP_STORE;
					nvm_req.page <= eca_pkg::PAGE_USER;
				end else begin
					cmd_refused <= 1'b1;
				end
			end else if (cmd.valid && cmd.code == eca_pkg::CMD_RESTORE_USER) begin
				nvm_req.op   <= eca_pkg::OP_RESTORE;
				nvm_req.page <= eca_pkg::PAGE_USER;
			end else if (cmd.valid && cmd.code == eca_pkg::CMD_RESTORE_DEFAULT) begin
				nvm_req.op   <= eca_pkg::OP_RESTORE;
				nvm_req.page <= eca_pkg::PAGE_DEFAULT;
			end else if (rd && (cmd.code == eca_pkg::CMD_ERASE ||
				cmd.code == eca_pkg::CMD_NVM_KEY || cmd.code == eca_pkg::CMD_TRIM_KEY)) begin
				cmd_refused <= 1'b1;
			end
		end
	end

	sequence s_key_wr;
		wr && cmd.code == eca_pkg::CMD_NVM_KEY;
	endsequence

	sequence s_key_twice;
		(s_key_wr and cmd.data[7:0] == key_q) ##1 !cmd.valid ##1
		(s_key_wr and cmd.data[7:0] == $past(cmd.data[7:0], 2));
	endsequence

	// Trim key writes are judged against the EEPROM key
	sequence s_trim_good;
		wr && cmd.code == eca_pkg::CMD_TRIM_KEY && cmd.data[7:0] == key_q;
	endsequence

	chk_crc_readback: assert property (@(posedge clk) disable iff (!nrst)
		crc_valid ##1 !crc_valid ##1 (rd && cmd.code == eca_pkg::CMD_CHECKSUM && !crc_valid)
		|=> rsp_valid && rsp_data == {8'h00, $past(crc_value, 3)})
		else $error("checksum readback wrong");

	chk_len_roundtrip: assert property (@(posedge clk) disable iff (!nrst)
		(wr && cmd.code == eca_pkg::CMD_RD_LEN) ##1 !(wr && cmd.code == eca_pkg::CMD_RD_LEN) ##1
		(rd && cmd.code == eca_pkg::CMD_RD_LEN)
		|=> rsp_data == {8'h00, $past(cmd.data[7:0], 3)})
		else $error("read length not kept");

	chk_offset_roundtrip: assert property (@(posedge clk) disable iff (!nrst)
		(wr && cmd.code == eca_pkg::CMD_OFFSET) ##1 !(wr && cmd.code == eca_pkg::CMD_OFFSET) ##1
		(rd && cmd.code == eca_pkg::CMD_OFFSET)
		|=> rsp_data == $past(cmd.data, 3))
		else $error("address offset not kept");

	chk_erase_gate: assert property (@(posedge clk) disable iff (!nrst)
		nvm_req.op == eca_pkg::OP_ERASE |-> $past(nvm_unlocked) && nvm_req.page >= 4'h4)
		else $error("erase while locked or on low page");

	chk_erase_low_pages: assert property (@(posedge clk) disable iff (!nrst)
		(wr && cmd.code == eca_pkg::CMD_ERASE && cmd.data[7:0] < 8'h02)
		|=> nvm_req.op == eca_pkg::OP_NONE && cmd_refused)
		else $error("page 0 or 1 erase accepted");

	chk_key_unlock: assert property (@(posedge clk) disable iff (!nrst)
		!key_pend_q ##0 s_key_twice |=> nvm_unlocked)
		else $error("double key write did not unlock");

	chk_key_interrupt: assert property (@(posedge clk) disable iff (!nrst)
		((!nvm_unlocked && !key_pend_q) and s_key_wr) ##1 !cmd.valid ##1
		(cmd.valid && cmd.code != eca_pkg::CMD_NVM_KEY) ##1 !cmd.valid ##1 s_key_wr
		|=> !nvm_unlocked)
		else $error("interrupted key sequence unlocked");

	chk_trim_relock: assert property (@(posedge clk) disable iff (!nrst)
		(wr && cmd.code == eca_pkg::CMD_TRIM_KEY && cmd.data[7:0] != key_q)
		|=> !trim_unlocked)
		else $error("wrong trim key kept unlock");

	chk_store_gate: assert property (@(posedge clk) disable iff (!nrst)
		(cmd.valid && cmd.code == eca_pkg::CMD_STORE_USER)
		|=> (nvm_req.op == eca_pkg::OP_STORE) == $past(nvm_unlocked))
		else $error("store user gating wrong");

	chk_data_write_range: assert property (@(posedge clk) disable iff (!nrst)
		nvm_req.op == eca_pkg::OP_WRITE |-> nvm_req.page >= 4'h4)
		else $error("data write to protected page");

	chk_trim_unlock: assert property (@(posedge clk) disable iff (!nrst)
		s_trim_good ##1 !cmd.valid ##1 s_trim_good |=> trim_unlocked)
		else $error("double trim key did not unlock");

	chk_erase_accept: assert property (@(posedge clk) disable iff (!nrst)
		(wr && cmd.code == eca_pkg::CMD_ERASE && nvm_unlocked &&
		cmd.data[7:0] >= eca_pkg::PAGE_FIRST_WR && cmd.data[7:0] <= eca_pkg::PAGE_LAST)
		|=> nvm_req.op == eca_pkg::OP_ERASE && nvm_req.page == $past(cmd.data[3:0]))
		else $error("valid erase not issued");

	chk_data_read_map: assert property (@(posedge clk) disable iff (!nrst)
		(rd && cmd.code[7:4] == eca_pkg::CMD_DATA_NIBBLE)
		|=> nvm_req.op == eca_pkg::OP_READ && nvm_req.page == $past(cmd.code[3:0]))
		else $error("data read not mapped to page");

	chk_flag_readback: assert property (@(posedge clk) disable iff (!nrst)
		(rd && cmd.code == eca_pkg::CMD_FLAG_INFO)
		|=> rsp_valid && rsp_data == {8'h00, $past(flag_info)})
		else $error("flag info readback wrong");

	chk_store_page: assert property (@(posedge clk) disable iff (!nrst)
		nvm_req.op == eca_pkg::OP_STORE |-> nvm_req.page == eca_pkg::PAGE_USER)
		else $error("store user not aimed at user page");

	chk_restore_user: assert property (@(posedge clk) disable iff (!nrst)
		(cmd.valid && cmd.code == eca_pkg::CMD_RESTORE_USER)
		|=> nvm_req.op == eca_pkg::OP_RESTORE && nvm_req.page == eca_pkg::PAGE_USER)
		else $error("restore user wrong");

	chk_restore_default: assert property (@(posedge clk) disable iff (!nrst)
		(cmd.valid && cmd.code == eca_pkg::CMD_RESTORE_DEFAULT)
		|=> nvm_req.op == eca_pkg::OP_RESTORE && nvm_req.page == eca_pkg::PAGE_DEFAULT)
		else $error("restore default wrong");

	// No disable here: the locks must read closed while reset is held
	chk_reset_locks: assert property (@(posedge clk)
		!nrst |-> !nvm_unlocked && !trim_unlocked && !key_pend_q && !trim_pend_q)
		else $error("lock open during reset");
endmodule // eca_core

// ===== eca_host.sv
// Host model that issues one decoded command at a time to the block
module eca_host #(
	// Stands in for the 35 ms erase gap, scaled down to keep runs short
	parameter int ERASE_GAP = 20
) (
	input  wire logic         clk,
	output eca_pkg::eca_cmd_t cmd
);
	timeunit 1ns;
	timeprecision 100ps;
	initial cmd = '0;
	task automatic send(input logic w, input logic [7:0] code, input logic [15:0] data);
		@(posedge clk);
		#1 cmd = {1'h1, w, code, data};
		@(posedge clk);
		// Released fields show the inverse so stale values never match
		#1 cmd = {1'h0, ~w, ~code, ~data};
	endtask
	task automatic gap();
		repeat (ERASE_GAP) @(posedge clk);
	endtask
endmodule : eca_host

// ===== eeprom_command_access_tb.sv
// Self-checking bench for the EEPROM command access block
module eeprom_command_access_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic              clk, nrst, crc_valid, rsp_valid, nvm_unlocked, trim_unlocked, cmd_refused;
	logic [7:0]        crc_value, flag_info;
	logic [15:0]       rsp_data;
	eca_pkg::eca_cmd_t cmd;
	eca_pkg::eca_nvm_t nvm_req;
	int                failures = 0;
	int                n_checks = 0;
	eca_host u_host (.clk(clk), .cmd(cmd));
	eca_core dut (.clk(clk), .nrst(nrst), .cmd(cmd), .crc_valid(crc_valid),
		.crc_value(crc_value), .flag_info(flag_info), .rsp_valid(rsp_valid),
		.rsp_data(rsp_data), .nvm_req(nvm_req), .nvm_unlocked(nvm_unlocked),
		.trim_unlocked(trim_unlocked), .cmd_refused(cmd_refused));
	task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic rd(input logic [7:0] code, input logic [15:0] exp);
		u_host.send(1'h0, code, 16'h0000);
		chk("rsp", {31'h0, 1'h1, exp}, {31'h0, rsp_valid, rsp_data});
	endtask
	task automatic opchk(input eca_pkg::eca_op_t op, input logic [3:0] page, input logic ref_exp);
		chk("nvm op", {40'h0, ref_exp, op, page}, {40'h0, cmd_refused, nvm_req.op, nvm_req.page});
	endtask
	task automatic t_reset();
		chk("rst", 48'h0, {5'h0, rsp_valid, nvm_unlocked, trim_unlocked, cmd_refused, nvm_req});
		rd(eca_pkg::CMD_RD_LEN, 16'h0000);
		rd(eca_pkg::CMD_OFFSET, 16'h0000);
		rd(eca_pkg::CMD_CHECKSUM, 16'h0000);
	endtask
	task automatic t_regs();
		u_host.send(1'h1, eca_pkg::CMD_RD_LEN, 16'h005a);
		rd(eca_pkg::CMD_RD_LEN, 16'h005a);
		u_host.send(1'h1, eca_pkg::CMD_OFFSET, 16'hbeef);
		rd(eca_pkg::CMD_OFFSET, 16'hbeef);
		@(posedge clk);
		#1 crc_valid = 1'h1;
		crc_value = 8'h3c;
		@(posedge clk);
		#1 crc_valid = 1'h0;
		crc_value = 8'hc3;
		rd(eca_pkg::CMD_CHECKSUM, 16'h003c);
		// A write to the checksum must not disturb it
		u_host.send(1'h1, eca_pkg::CMD_CHECKSUM, 16'h0077);
		rd(eca_pkg::CMD_CHECKSUM, 16'h003c);
		rd(eca_pkg::CMD_ERASE, 16'h0000);
		chk("refused", 48'h1, {47'h0, cmd_refused});
	endtask
	task automatic t_locked();
		u_host.send(1'h1, eca_pkg::CMD_ERASE, 16'h0005);
		opchk(eca_pkg::OP_NONE, 4'h0, 1'h1);
		u_host.send(1'h1, eca_pkg::CMD_STORE_USER, 16'h0000);
		opchk(eca_pkg::OP_NONE, 4'h0, 1'h1);
	endtask
	task automatic t_unlock();
		u_host.send(1'h1, eca_pkg::CMD_NVM_KEY, 16'h00ff);
		rd(eca_pkg::CMD_RD_LEN, 16'h005a);
		u_host.send(1'h1, eca_pkg::CMD_NVM_KEY, 16'h00ff);
		chk("nvm lock", 48'h0, {47'h0, nvm_unlocked});
		u_host.send(1'h1, eca_pkg::CMD_NVM_KEY, 16'h00ff);
		chk("nvm lock", 48'h1, {47'h0, nvm_unlocked});
	endtask
	task automatic t_erase();
		logic [7:0] pages [5] = '{8'h00, 8'h01, 8'h04, 8'h0f, 8'h10};
		logic       ok;
		logic [3:0] held = 4'h0;
		// Pages 2 and 3 are left alone on purpose
		foreach (pages[i]) begin
			ok = pages[i] >= eca_pkg::PAGE_FIRST_WR && pages[i] <= eca_pkg::PAGE_LAST;
			// A refused erase leaves the page field of the last op standing
			held = ok ? pages[i][3:0] : held;
			u_host.send(1'h1, eca_pkg::CMD_ERASE, {8'h00, pages[i]});
			opchk(ok ? eca_pkg::OP_ERASE : eca_pkg::OP_NONE, held, !ok);
			u_host.gap();
		end
	endtask
	task automatic t_trim();
		u_host.send(1'h1, eca_pkg::CMD_NVM_KEY, 16'h00a5);
		u_host.send(1'h1, eca_pkg::CMD_NVM_KEY, 16'h00a5);
		u_host.send(1'h1, eca_pkg::CMD_TRIM_KEY, 16'h00ff);
		u_host.send(1'h1, eca_pkg::CMD_TRIM_KEY, 16'h00ff);
		chk("trim lock", 48'h0, {47'h0, trim_unlocked});
		u_host.send(1'h1, eca_pkg::CMD_TRIM_KEY, 16'h00a5);
		u_host.send(1'h1, eca_pkg::CMD_TRIM_KEY, 16'h00a5);
		chk("trim lock", 48'h1, {47'h0, trim_unlocked});
		u_host.send(1'h1, eca_pkg::CMD_TRIM_KEY, 16'h003c);
		chk("trim lock", 48'h0, {47'h0, trim_unlocked});
	endtask
	task automatic t_pages();
		u_host.send(1'h0, 8'hb7, 16'h0000);
		chk("rd req", {17'h0, eca_pkg::OP_READ, 4'h7, 16'hbeef, 8'h5a}, 48'(nvm_req[38:8]));
		u_host.send(1'h1, 8'hb2, 16'h0011);
		opchk(eca_pkg::OP_NONE, 4'h7, 1'h1);
		u_host.send(1'h1, 8'hb9, 16'h0022);
		opchk(eca_pkg::OP_WRITE, 4'h9, 1'h0);
		rd(eca_pkg::CMD_FLAG_INFO, 16'h00c3);
		u_host.send(1'h1, eca_pkg::CMD_STORE_USER, 16'h0000);
		opchk(eca_pkg::OP_STORE, eca_pkg::PAGE_USER, 1'h0);
		u_host.send(1'h0, eca_pkg::CMD_RESTORE_USER, 16'h0000);
		opchk(eca_pkg::OP_RESTORE, eca_pkg::PAGE_USER, 1'h0);
		u_host.send(1'h1, eca_pkg::CMD_RESTORE_DEFAULT, 16'h0000);
		opchk(eca_pkg::OP_RESTORE, eca_pkg::PAGE_DEFAULT, 1'h0);
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end
	initial begin
		repeat (5000) @(posedge clk);
		failures++;
		close_out();
	end
	initial begin
		nrst = 1'h0;
		crc_valid = 1'h0;
		crc_value = 8'h00;
		flag_info = 8'hc3;
		repeat (6) @(posedge clk);
		#1 nrst = 1'h1;
		t_reset();
		t_regs();
		t_locked();
		t_unlock();
		t_erase();
		t_trim();
		t_pages();
		close_out();
	end
endmodule : eeprom_command_access_tb
